/* File: logic/ocot_map.svh */
// Offsets, field positions, reset values and fixed codes of the output current offset trim
`ifndef OCOT_MAP_SVH
`define OCOT_MAP_SVH

// ==========================================================
// Command code and paging
`define OCOT_CMD_CODE 8'h39
`define OCOT_PAGE_HI_BIT 7
`define OCOT_PAGE_LO_BIT 0
`define OCOT_PSEL_CH1 2'h0
`define OCOT_PSEL_CH2 2'h1
`define OCOT_PSEL_BAD 2'h2
`define OCOT_PSEL_BOTH 2'h3

// ==========================================================
// Word layout: exponent, sign-extended and writable mantissa bits
`define OCOT_WORD_W 16
`define OCOT_EXP_MSB 15
`define OCOT_EXP_LSB 11
`define OCOT_EXP_FIXED 5'h1C
`define OCOT_SIGN_BIT 10
`define OCOT_EXT_W 4
`define OCOT_LOW_MSB 5
`define OCOT_LOW_LSB 0
`define OCOT_TRIM_W 7

// ==========================================================
// Reset value of the writable trim (zero amperes) and current width
`define OCOT_TRIM_RESET 7'h00
`define OCOT_CUR_W 16

`endif

/* File: logic/ocot_pkg.sv */
// Types shared by the output current offset trim
package ocot_pkg;
`include "ocot_map.svh"

    // ==========================================================
    // Per-channel measurement inputs, in steps of the trim lsb
    typedef struct packed {
        logic signed [`OCOT_CUR_W-1:0] iout_raw;
        logic signed [`OCOT_CUR_W-1:0] warn_lim;
        logic signed [`OCOT_CUR_W-1:0] fault_lim;
    } ocot_meas_t;

    // ==========================================================
    // Per-channel corrected results
    typedef struct packed {
        logic signed [`OCOT_CUR_W-1:0] iout_corr;
        logic oc_warn;
        logic oc_fault;
    } ocot_res_t;

    // ==========================================================
    // Command handed over by the PMBus front end
    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [`OCOT_WORD_W-1:0] wdata;
        logic [7:0] page;
    } ocot_cmd_t;

    // ==========================================================
    // Answer handed back to the PMBus front end
    typedef struct packed {
        logic ack;
        logic [`OCOT_WORD_W-1:0] rdata;
    } ocot_rsp_t;

endpackage : ocot_pkg

/* File: logic/ocot_trim.sv */
// Paged output current offset trim register with current correction and overcurrent checks
`timescale 1ns/10ps
`include "ocot_map.svh"
// What this block does
// R01: The stored offset is added to the output current readback and to both overcurrent comparisons.
// R02: The offset counts in steps of 62.5 mA and starts at zero amperes after power-up.
// R03: The offset spans -4 A to 3.9375 A and out-of-range writes are aliased by the fixed bits, not checked.
// R04: The exponent field in bits 15:11 always reads 11100, minus four, and cannot be written.
// R05: Mantissa bits 9:8 and 7:6 are always copies of the mantissa sign bit 10.
// R06: Values written to read-only bit positions are discarded and their fixed contents kept.
// R07: Page bits 7 and 0 select channel 1 at 00, channel 2 at 01 and both channels at 11.
// R08: Channel 1 always takes page 00 writes, broadcasts only with channel 2 master; channel 2 only as master, a slave one using channel 1's value.
// R09: A write aimed at a slave channel 2 is NACKed, records an invalid value fault and asserts SMBALERT.
// R10: In 3- or 4-phase use the host gives the second device's channel 1 the master's value; nothing enforces it.
// R11: The user store command saves the current settings so they become the power-up default.
// R12: The register moves as a 16-bit word, low byte first, worth the sign-extended mantissa times 2^exponent.

module ocot_trim
    import ocot_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Command port from the PMBus front end
    input wire logic CMD_VALID,
    input ocot_cmd_t CMD,
    output logic RSP_VALID,
    output ocot_rsp_t RSP,
    // Phase configuration
    input wire logic CH2_SLAVE,
    // Non-volatile user store
    input wire logic STORE_USER,
    output logic NV_STORE_STB,
    output logic [`OCOT_WORD_W-1:0] NV_STORE_CH1,
    output logic [`OCOT_WORD_W-1:0] NV_STORE_CH2,
    input wire logic NV_LOAD,
    input wire logic [`OCOT_WORD_W-1:0] NV_LOAD_CH1,
    input wire logic [`OCOT_WORD_W-1:0] NV_LOAD_CH2,
    // Fault reporting
    input wire logic FAULT_CLR,
    output logic INVALID_VALUE_FAULT,
    output logic SMBALERT_N,
    // Current measurement and overcurrent results
    input ocot_meas_t MEAS_CH1,
    input ocot_meas_t MEAS_CH2,
    output ocot_res_t RES_CH1,
    output ocot_res_t RES_CH2
);

    // ==========================================================
    // Helper functions

    // Build the full word from the writable trim; fixed and extended bits are regenerated here
    function automatic logic [`OCOT_WORD_W-1:0] pack_word(input logic [`OCOT_TRIM_W-1:0] trim);
        logic s;
        s = trim[`OCOT_TRIM_W-1];
        pack_word = {`OCOT_EXP_FIXED, s, {`OCOT_EXT_W{s}}, trim[`OCOT_LOW_MSB:`OCOT_LOW_LSB]}; // R04 R05 R12
    endfunction : pack_word

    // Keep only the writable bits of a written word; everything else is dropped
    function automatic logic [`OCOT_TRIM_W-1:0] unpack_word(input logic [`OCOT_WORD_W-1:0] w);
        unpack_word = {w[`OCOT_SIGN_BIT], w[`OCOT_LOW_MSB:`OCOT_LOW_LSB]}; // R03 R06
    endfunction : unpack_word

    // Offset sign-extended to one bit beyond current width; one step is 62.5 mA
    function automatic logic signed [`OCOT_CUR_W:0] widen(input logic [`OCOT_TRIM_W-1:0] trim);
        widen = {{(`OCOT_CUR_W+1-`OCOT_TRIM_W){trim[`OCOT_TRIM_W-1]}}, trim}; // R02
    endfunction : widen

    // Add the offset with saturation so a corrected value never wraps sign
    function automatic logic signed [`OCOT_CUR_W-1:0] corr(
        input logic signed [`OCOT_CUR_W-1:0] raw,
        input logic [`OCOT_TRIM_W-1:0] trim
    );
        logic signed [`OCOT_CUR_W:0] sum;
        sum = {raw[`OCOT_CUR_W-1], raw} + widen(trim);
        if (sum[`OCOT_CUR_W] != sum[`OCOT_CUR_W-1]) begin
            corr = {sum[`OCOT_CUR_W], {(`OCOT_CUR_W-1){~sum[`OCOT_CUR_W]}}};
        end else begin
            corr = sum[`OCOT_CUR_W-1:0];
        end
    endfunction : corr

    // One comparison path shared by both channels; each compares against its own warn and fault limits
    function automatic ocot_res_t oc_check(
        input logic signed [`OCOT_CUR_W-1:0] c,
        input ocot_meas_t m
    );
        ocot_res_t r;
        r.iout_corr = c; // R01
        r.oc_warn = c > m.warn_lim; // R01
        r.oc_fault = c > m.fault_lim; // R01
        oc_check = r;
    endfunction : oc_check

    // ==========================================================
    // Command decode

    logic [1:0] psel;
    logic hit;
    logic wr_req;
    logic rd_req;
    logic wr_ch1;
    logic wr_ch2;
    logic wr_reject;
    logic [`OCOT_TRIM_W-1:0] wr_trim;

    assign psel = {CMD.page[`OCOT_PAGE_HI_BIT], CMD.page[`OCOT_PAGE_LO_BIT]}; // R07
    assign hit = CMD_VALID && (CMD.code == `OCOT_CMD_CODE);
    assign wr_req = hit && CMD.write;
    assign rd_req = hit && !CMD.write;
    assign wr_trim = unpack_word(CMD.wdata); // R06

    always_comb begin
        wr_ch1 = 1'b0;
        wr_ch2 = 1'b0;
        wr_reject = 1'b0;
        unique case (psel) // R07
            `OCOT_PSEL_CH1: begin
                wr_ch1 = wr_req; // R08
            end
            `OCOT_PSEL_CH2: begin
                wr_ch2 = wr_req && !CH2_SLAVE; // R08
                wr_reject = wr_req && CH2_SLAVE; // R09
            end
            `OCOT_PSEL_BOTH: begin
                // A slave channel 2 refuses the whole broadcast so the channels never part silently
                wr_ch1 = wr_req && !CH2_SLAVE;
                wr_ch2 = wr_req && !CH2_SLAVE; // R08
                wr_reject = wr_req && CH2_SLAVE; // R09
            end
            `OCOT_PSEL_BAD: begin
                wr_reject = wr_req;
            end
        endcase
    end

    // ==========================================================
    // Trim storage, one writable field per channel

    logic [`OCOT_TRIM_W-1:0] trim_ch1_r;
    logic [`OCOT_TRIM_W-1:0] trim_ch2_r;
    logic [`OCOT_TRIM_W-1:0] eff_ch2;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            trim_ch1_r <= `OCOT_TRIM_RESET; // R02
        end else if (wr_ch1) begin
            trim_ch1_r <= wr_trim; // R03
        end else if (NV_LOAD) begin
            trim_ch1_r <= unpack_word(NV_LOAD_CH1); // R11
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            trim_ch2_r <= `OCOT_TRIM_RESET; // R02
        end else if (wr_ch2) begin
            trim_ch2_r <= wr_trim; // R03
        end else if (NV_LOAD) begin
            trim_ch2_r <= unpack_word(NV_LOAD_CH2); // R11
        end
    end

    // A slave channel 2 follows channel 1 rather than its own copy
    assign eff_ch2 = CH2_SLAVE ? trim_ch1_r : trim_ch2_r; // R08

    // ==========================================================
    // Answer to the front end, one cycle after the command

    logic rsp_valid_r;
    logic rsp_ack_r;
    logic [`OCOT_WORD_W-1:0] rsp_data_r;
    logic [`OCOT_TRIM_W-1:0] rd_trim;

    always_comb begin
        rd_trim = trim_ch1_r;
        if (psel == `OCOT_PSEL_CH2) begin
            rd_trim = eff_ch2; // R07 R08
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= hit;
        end
    end

    // Reads always succeed; a refused write is answered with NACK
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_ack_r <= 1'b0;
        end else begin
            rsp_ack_r <= hit && !wr_reject; // R09
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_data_r <= '0;
        end else if (rd_req) begin
            rsp_data_r <= pack_word(rd_trim); // R04 R05 R12
        end
    end

    assign RSP_VALID = rsp_valid_r;
    assign RSP.ack = rsp_ack_r;
    assign RSP.rdata = rsp_data_r;

    // ==========================================================
    // Invalid value fault and alert

    logic ivf_r;

    // Set wins over clear so a refusal in the clearing cycle is not lost
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ivf_r <= 1'b0;
        end else if (wr_reject) begin
            ivf_r <= 1'b1; // R09
        end else if (FAULT_CLR) begin
            ivf_r <= 1'b0;
        end
    end

    assign INVALID_VALUE_FAULT = ivf_r;

    logic alert_n_r;

    // The alert pin gets a flop of its own so it never carries a glitch from decode logic
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            alert_n_r <= 1'b1;
        end else if (wr_reject) begin
            alert_n_r <= 1'b0; // R09
        end else if (FAULT_CLR) begin
            alert_n_r <= 1'b1;
        end
    end

    assign SMBALERT_N = alert_n_r; // R09

    // ==========================================================
    // User store: snapshot of the present settings for non-volatile memory

    logic nv_stb_r;
    logic [`OCOT_WORD_W-1:0] nv_ch1_r;
    logic [`OCOT_WORD_W-1:0] nv_ch2_r;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            nv_stb_r <= 1'b0;
        end else begin
            nv_stb_r <= STORE_USER; // R11
        end
    end

    // Channel 2 stores its own copy, so a later master setup keeps it
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            nv_ch1_r <= '0;
            nv_ch2_r <= '0;
        end else if (STORE_USER) begin
            nv_ch1_r <= pack_word(trim_ch1_r); // R11
            nv_ch2_r <= pack_word(trim_ch2_r); // R11
        end
    end

    assign NV_STORE_STB = nv_stb_r;
    assign NV_STORE_CH1 = nv_ch1_r;
    assign NV_STORE_CH2 = nv_ch2_r;

    // ==========================================================
    // Corrected current and overcurrent comparisons

    logic signed [`OCOT_CUR_W-1:0] corr_ch1;
    logic signed [`OCOT_CUR_W-1:0] corr_ch2;
    ocot_res_t res_ch1_r;
    ocot_res_t res_ch2_r;

    assign corr_ch1 = corr(MEAS_CH1.iout_raw, trim_ch1_r); // R01
    assign corr_ch2 = corr(MEAS_CH2.iout_raw, eff_ch2); // R01 R08

    // Results are registered, so they lag the measurement by one cycle
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            res_ch1_r <= '0;
        end else begin
            res_ch1_r <= oc_check(corr_ch1, MEAS_CH1); // R01
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            res_ch2_r <= '0;
        end else begin
            res_ch2_r <= oc_check(corr_ch2, MEAS_CH2); // R01
        end
    end

    assign RES_CH1 = res_ch1_r;
    assign RES_CH2 = res_ch2_r;

endmodule : ocot_trim

/* File: verification/ocot_trim_assertions.sv */
// Assertion checker for the output current offset trim ports
`timescale 1ns/10ps
// ====================
// Checker
module ocot_trim_chk
    import ocot_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Command port
    input wire logic CMD_VALID,
    input ocot_cmd_t CMD,
    input logic RSP_VALID,
    input ocot_rsp_t RSP,
    // Configuration, store and faults
    input wire logic CH2_SLAVE,
    input wire logic STORE_USER,
    input logic NV_STORE_STB,
    input logic [15:0] NV_STORE_CH1,
    input wire logic FAULT_CLR,
    input logic INVALID_VALUE_FAULT,
    input logic SMBALERT_N
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    sequence s_cmd; CMD_VALID && CMD.code == 8'h39; endsequence
    sequence s_rd; s_cmd ##0 !CMD.write; endsequence
    sequence s_bad; s_cmd ##0 (CMD.write && CH2_SLAVE && CMD.page[0]); endsequence
    sequence s_ch1; s_cmd ##0 (CMD.write && !CMD.page[0] && !CMD.page[7]); endsequence
    property p_rsp; s_cmd |=> RSP_VALID; endproperty
    a_rsp: assert property (p_rsp) else $error("command not answered");
    property p_quiet; CMD_VALID && CMD.code != 8'h39 |=> !RSP_VALID; endproperty
    a_quiet: assert property (p_quiet) else $error("foreign code answered");
    property p_exp; s_rd |=> RSP.rdata[15:11] == 5'h1C; endproperty
    a_exp: assert property (p_exp) else $error("exponent not fixed");
    property p_sext; s_rd |=> RSP.rdata[9:6] == {4{RSP.rdata[10]}}; endproperty
    a_sext: assert property (p_sext) else $error("mantissa not sign extended");
    property p_ch1; s_ch1 |=> RSP_VALID && RSP.ack; endproperty
    a_ch1: assert property (p_ch1) else $error("channel 1 write refused");
    property p_nack; s_bad |=> RSP_VALID && !RSP.ack && INVALID_VALUE_FAULT; endproperty
    a_nack: assert property (p_nack) else $error("slave write not refused");
    property p_alert; SMBALERT_N == !INVALID_VALUE_FAULT; endproperty
    a_alert: assert property (p_alert) else $error("alert does not follow fault");
    property p_sticky; INVALID_VALUE_FAULT && !FAULT_CLR |=> INVALID_VALUE_FAULT; endproperty
    a_sticky: assert property (p_sticky) else $error("fault lost");
    property p_store; STORE_USER |=> NV_STORE_STB && NV_STORE_CH1[15:11] == 5'h1C; endproperty
    a_store: assert property (p_store) else $error("store not strobed");
endmodule : ocot_trim_chk

bind ocot_trim ocot_trim_chk chk_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .RSP_VALID(RSP_VALID), .RSP(RSP), .CH2_SLAVE(CH2_SLAVE), .STORE_USER(STORE_USER),
    .NV_STORE_STB(NV_STORE_STB), .NV_STORE_CH1(NV_STORE_CH1), .FAULT_CLR(FAULT_CLR),
    .INVALID_VALUE_FAULT(INVALID_VALUE_FAULT), .SMBALERT_N(SMBALERT_N));

/* File: verification/ocot_host_model.sv */
// Host controller model driving the trim's command port
`timescale 1ns/10ps
// ====================
// Host model
module ocot_host_model
    import ocot_pkg::*;
(
    // Clock
    input wire logic SYS_CLK,
    // Command port
    output logic CMD_VALID,
    output ocot_cmd_t CMD,
    input wire logic RSP_VALID,
    input ocot_rsp_t RSP
);
    initial begin
        CMD_VALID = 1'b0;
        CMD = '0;
    end
    // Whole paged word per command; matching values across devices is left to the caller
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] pg, input logic [15:0] dat,
                        output logic vld, output logic ack, output logic [15:0] rd);
        @(posedge SYS_CLK);
        #1;
        CMD_VALID = 1'b1;
        CMD = '{write: w, code: c, wdata: dat, page: pg};
        // Taken at this edge; the registered answer stands for the cycle that follows
        @(posedge SYS_CLK);
        #1;
        vld = RSP_VALID;
        ack = RSP.ack;
        rd = RSP.rdata;
        CMD_VALID = 1'b0;
        // Released lines must not keep the last value
        CMD = ~CMD;
    endtask : xfer
endmodule : ocot_host_model

/* File: verification/testbench.sv */
// Self-checking testbench of the output current offset trim
`timescale 1ns/10ps
// ====================
// Testbench
module testbench;
    import ocot_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic ch2_slave = 1'b0;
    logic store_user = 1'b0;
    logic nv_load = 1'b0;
    logic fault_clr = 1'b0;
    logic cmd_valid, rsp_valid, nv_stb, ivf, alert_n, v, a;
    ocot_cmd_t cmd;
    ocot_rsp_t rsp;
    ocot_meas_t m1 = '{16'sh0064, 16'sh0060, 16'sh0068};
    ocot_meas_t m2 = '{16'sh0064, 16'sh0060, 16'sh0068};
    ocot_res_t r1, r2;
    logic [15:0] nvs1, nvs2, d;
    logic [15:0] nvl1 = 16'hFC05;
    logic [15:0] nvl2 = 16'h0002;
    logic [15:0] tbl [4] = '{16'hFFFF, 16'h03BF, 16'hE401, 16'h043C};
    int miscompares = 0;
    int compares = 0;

    always #2.5 sys_clk = ~sys_clk;

    ocot_host_model host_u (.SYS_CLK(sys_clk), .CMD_VALID(cmd_valid), .CMD(cmd), .RSP_VALID(rsp_valid), .RSP(rsp));
    ocot_trim dut_u (.SYS_CLK(sys_clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD(cmd), .RSP_VALID(rsp_valid),
        .RSP(rsp), .CH2_SLAVE(ch2_slave), .STORE_USER(store_user), .NV_STORE_STB(nv_stb),
        .NV_STORE_CH1(nvs1), .NV_STORE_CH2(nvs2), .NV_LOAD(nv_load), .NV_LOAD_CH1(nvl1),
        .NV_LOAD_CH2(nvl2), .FAULT_CLR(fault_clr), .INVALID_VALUE_FAULT(ivf), .SMBALERT_N(alert_n),
        .MEAS_CH1(m1), .MEAS_CH2(m2), .RES_CH1(r1), .RES_CH2(r2));

    function automatic logic [15:0] ew(input logic [15:0] w);
        return {5'h1C, {5{w[10]}}, w[5:0]};
    endfunction : ew

    task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk_w

    task automatic chk_b(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %b seen %b", n, e, g);
        end
    endtask : chk_b

    task automatic wr(input logic [7:0] pg, input logic [15:0] w, input logic ea);
        host_u.xfer(1'b1, 8'h39, pg, w, v, a, d);
        chk_b("rsp_valid", 1'b1, v);
        chk_b("ack", ea, a);
    endtask : wr

    task automatic rd(input logic [7:0] pg, input logic [15:0] e);
        host_u.xfer(1'b0, 8'h39, pg, 16'h0000, v, a, d);
        chk_b("read rsp_valid", 1'b1, v);
        chk_b("read ack", 1'b1, a);
        chk_w("rdata", e, d);
    endtask : rd

    // Offset is the sign plus six writable bits, in 62.5 mA steps
    task automatic cur(input ocot_res_t r, input ocot_meas_t m, input logic [15:0] w);
        logic signed [15:0] e;
        e = m.iout_raw + $signed({{9{w[10]}}, w[10], w[5:0]});
        chk_w("iout_corr", e, r.iout_corr);
        chk_b("oc_warn", e > m.warn_lim, r.oc_warn);
        chk_b("oc_fault", e > m.fault_lim, r.oc_fault);
    endtask : cur

    task automatic pulse(ref logic s);
        @(posedge sys_clk);
        #1;
        s = 1'b1;
        @(posedge sys_clk);
        #1;
        s = 1'b0;
    endtask : pulse

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Tests take under a hundred cycles; four thousand means a hang
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        rd(8'h00, 16'hE000);
        cur(r1, m1, 16'h0000);
        $display("test reset done");
        foreach (tbl[i]) begin
            wr(8'h00, tbl[i], 1'b1);
            rd(8'h00, ew(tbl[i]));
            cur(r1, m1, tbl[i]);
        end
        host_u.xfer(1'b1, 8'h38, 8'h00, 16'h0001, v, a, d);
        chk_b("foreign rsp_valid", 1'b0, v);
        $display("test format done");
        wr(8'h01, 16'h0002, 1'b1);
        rd(8'h01, ew(16'h0002));
        rd(8'h00, ew(16'h043C));
        wr(8'h81, 16'h0401, 1'b1);
        rd(8'h00, ew(16'h0401));
        rd(8'h01, ew(16'h0401));
        cur(r2, m2, 16'h0401);
        $display("test paging done");
        ch2_slave = 1'b1;
        wr(8'h01, 16'h0003, 1'b0);
        chk_b("fault", 1'b1, ivf);
        chk_b("alert_n", 1'b0, alert_n);
        wr(8'h00, 16'h0010, 1'b1);
        rd(8'h01, ew(16'h0010));
        cur(r2, m2, 16'h0010);
        wr(8'h81, 16'h0005, 1'b0);
        wr(8'h80, 16'h0005, 1'b0);
        rd(8'h00, ew(16'h0010));
        pulse(fault_clr);
        chk_b("fault", 1'b0, ivf);
        ch2_slave = 1'b0;
        $display("test slave done");
        pulse(store_user);
        chk_b("store strobe", 1'b1, nv_stb);
        chk_w("store ch1", ew(16'h0010), nvs1);
        chk_w("store ch2", ew(16'h0401), nvs2);
        pulse(nv_load);
        rd(8'h00, ew(nvl1));
        rd(8'h01, ew(nvl2));
        $display("test store done");
        print_verdict();
    end
endmodule : testbench
